// ### design/nvmsda_map.vh
// Register offsets, field positions, codes and reset values of the status, data and address block.
`ifndef NVMSDA_MAP_VH
`define NVMSDA_MAP_VH
`define NVMSDA_OFF_STATUS     8'h02
`define NVMSDA_OFF_IRQ_EN     8'h03
`define NVMSDA_OFF_IRQ_FLAGS  8'h04
`define NVMSDA_OFF_DATA       8'h06
`define NVMSDA_OFF_ADDR       8'h08
`define NVMSDA_OFF_CMD        8'h0C
`define NVMSDA_OFF_EVENT      8'h0D
`define NVMSDA_IDX_W          8
`define NVMSDA_ERR_LSB        4
`define NVMSDA_ERR_MSB        6
`define NVMSDA_EEPROM_BUSY_BIT_BIT     1
`define NVMSDA_FLASH_BUSY_BIT_BIT      0
`define NVMSDA_EERDY_BIT      0
`define NVMSDA_ERR_NONE       3'h0
`define NVMSDA_ERR_INVALID    3'h1
`define NVMSDA_ERR_PROTECT    3'h2
`define NVMSDA_ERR_OVERLAP    3'h3
`define NVMSDA_RST_BYTE       8'h00
`define NVMSDA_RST_DATA       16'h0000
`define NVMSDA_RST_ADDR       24'h000000
`define NVMSDA_RST_IRQ_EN     1'b0
`define NVMSDA_RST_FLAG       1'b0
`endif

// ### design/nvmsda_err.v
// Error code holder that loads the latest programming error and clears on a software write of zero.
`timescale 1ns/1ps
`include "nvmsda_map.vh"
module nvmsda_err (
   input  wire       hclk,
   input  wire       hresetn,
   input  wire       err_invalid,
   input  wire       err_protect,
   input  wire       err_overlap,
   input  wire       sw_wr,
   input  wire [2:0] sw_val,
   output reg  [2:0] err_q
);
   reg [2:0] err_d;
   // Hardware errors win over a clear in the same cycle so no event is lost.
   always @* begin
      err_d = err_q;
      if (sw_wr && (sw_val == `NVMSDA_ERR_NONE)) begin
         err_d = `NVMSDA_ERR_NONE;
      end
      if (err_overlap) begin
         err_d = `NVMSDA_ERR_OVERLAP;
      end else if (err_protect) begin
         err_d = `NVMSDA_ERR_PROTECT;
      end else if (err_invalid) begin
         err_d = `NVMSDA_ERR_INVALID;
      end
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_q <= `NVMSDA_ERR_NONE;
      end else begin
         err_q <= err_d;
      end
   end
endmodule

// ### design/nvmsda_top.v
// AHB-Lite register block for status, interrupt, data and address of the nonvolatile controller.
// Overview of operation
// - Error field bits 6:4 holds last error
// - Writing zero clears the error field
// - Unsupported command loads code one
// - Protected section write loads code two
// - Command overlap loads code three
// - EEPROM busy bit 1 reads ongoing op
// - Flash busy bit 0 reads ongoing op
// - Enabled interrupt is level while flag set
// - Ready flag set whenever EEPROM idle
// - Writing one clears flag, zero ignored
// - Data register 16 bits, low/high bytes
// - Data holds most recent read value
// - EEPROM reads use only low byte
// - Address is 24 bits, three bytes
// - Extended address byte at base plus two
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "nvmsda_map.vh"
module nvmsda_top (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [2:0]  hburst,
   input  wire [3:0]  hprot,
   input  wire        hmastlock,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   input  wire        flash_busy,
   input  wire        eeprom_busy,
   input  wire        rd_valid,
   input  wire [1:0]  rd_source,
   input  wire [15:0] rd_value,
   input  wire        cmd_unsupported,
   input  wire        cmd_protected,
   input  wire        cmd_overlap,
   output wire        eeprom_ready_irq,
   output wire [23:0] target_address,
   output wire [15:0] write_data
);
   // Register index is the printed offset; byte address is four times it.
   function [`NVMSDA_IDX_W-1:0] reg_index;
      input [31:0] a;
      begin
         reg_index = a[`NVMSDA_IDX_W+1:2];
      end
   endfunction

   localparam [1:0] SRC_EEPROM = 2'h1;

   // Busy pins from the memory side cross into hclk through two flip-flops.
   reg  [1:0]  sync_fb_q;
   reg  [1:0]  sync_eb_q;
   wire        flash_busy_bit_s = sync_fb_q[1];
   wire        eeprom_busy_bit_s = sync_eb_q[1];
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_fb_q <= 2'b00;
         sync_eb_q <= 2'b00;
      end else begin
         sync_fb_q <= {sync_fb_q[0], flash_busy};
         sync_eb_q <= {sync_eb_q[0], eeprom_busy};
      end
   end

   // Address phase capture.
   reg         wr_pend_q;
   reg  [7:0]  wr_idx_q;
   reg  [3:0]  wr_be_q;
   wire        xfer = hsel && hready && htrans[1];
   wire [3:0]  be_now = (hsize == 3'h0) ? (4'h1 << haddr[1:0]) :
                        (hsize == 3'h1) ? (haddr[1] ? 4'hC : 4'h3) : 4'hF;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 8'h00;
         wr_be_q   <= 4'h0;
      end else begin
         wr_pend_q <= xfer && hwrite;
         if (xfer) begin
            wr_idx_q <= reg_index(haddr);
            wr_be_q  <= be_now;
         end
      end
   end
   // The slave answers with zero wait states and always OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   function wr_hit;
      input [7:0] idx;
      input [7:0] off;
      input       pend;
      begin
         wr_hit = pend && (idx == off);
      end
   endfunction

   wire w_status = wr_hit(wr_idx_q, `NVMSDA_OFF_STATUS, wr_pend_q) && wr_be_q[0];
   wire w_irq_en = wr_hit(wr_idx_q, `NVMSDA_OFF_IRQ_EN, wr_pend_q) && wr_be_q[0];
   wire w_flags  = wr_hit(wr_idx_q, `NVMSDA_OFF_IRQ_FLAGS, wr_pend_q) && wr_be_q[0];
   wire w_data   = wr_hit(wr_idx_q, `NVMSDA_OFF_DATA, wr_pend_q);
   wire w_addr   = wr_hit(wr_idx_q, `NVMSDA_OFF_ADDR, wr_pend_q);

   // Error field.
   wire [2:0] err_code;
   nvmsda_err u_err (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .err_invalid (cmd_unsupported),
      .err_protect (cmd_protected),
      .err_overlap (cmd_overlap),
      .sw_wr       (w_status),
      .sw_val      (hwdata[`NVMSDA_ERR_MSB:`NVMSDA_ERR_LSB]),
      .err_q       (err_code)
   );

   // Interrupt enable and ready flag.
   reg  irq_en_q;
   reg  eerdy_q;
   reg  eerdy_d;
   always @* begin
      eerdy_d = eerdy_q;
      if (w_flags && hwdata[`NVMSDA_EERDY_BIT]) begin
         eerdy_d = 1'b0;
      end
      // Setting while idle wins over a clear in the same cycle.
      if (!eeprom_busy_bit_s) begin
         eerdy_d = 1'b1;
      end
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_en_q <= `NVMSDA_RST_IRQ_EN;
         eerdy_q  <= `NVMSDA_RST_FLAG;
      end else begin
         eerdy_q <= eerdy_d;
         if (w_irq_en) begin
            irq_en_q <= hwdata[`NVMSDA_EERDY_BIT];
         end
      end
   end
   // Level request; software must launch before enabling and disable in the handler.
   assign eeprom_ready_irq = irq_en_q && eerdy_q;

   // Data register, byte lanes 0 and 1 for low and high.
   reg  [15:0] data_q;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_data
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               data_q[g*8+7:g*8] <= `NVMSDA_RST_BYTE;
            end else if (rd_valid && !(g == 1 && rd_source == SRC_EEPROM)) begin
               data_q[g*8+7:g*8] <= rd_value[g*8+7:g*8];
            end else if (w_data && wr_be_q[g]) begin
               data_q[g*8+7:g*8] <= hwdata[g*8+7:g*8];
            end
         end
      end
   endgenerate
   assign write_data = data_q;

   // Address register, lanes 0..2 for low, high and extended.
   reg  [23:0] addr_q;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_addr
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               addr_q[g*8+7:g*8] <= `NVMSDA_RST_BYTE;
            end else if (w_addr && wr_be_q[g]) begin
               addr_q[g*8+7:g*8] <= hwdata[g*8+7:g*8];
            end
         end
      end
   endgenerate
   assign target_address = addr_q;

   // Read data registered during the address phase so it stands in the data phase.
   reg [31:0] rd_d;
   always @* begin
      rd_d = 32'h00000000;
      case (reg_index(haddr))
         `NVMSDA_OFF_STATUS: begin
            rd_d[`NVMSDA_ERR_MSB:`NVMSDA_ERR_LSB] = err_code;
            rd_d[`NVMSDA_EEPROM_BUSY_BIT_BIT] = eeprom_busy_bit_s;
            rd_d[`NVMSDA_FLASH_BUSY_BIT_BIT]  = flash_busy_bit_s;
         end
         `NVMSDA_OFF_IRQ_EN: begin
            rd_d[`NVMSDA_EERDY_BIT] = irq_en_q;
         end
         `NVMSDA_OFF_IRQ_FLAGS: begin
            rd_d[`NVMSDA_EERDY_BIT] = eerdy_q;
         end
         `NVMSDA_OFF_DATA: begin
            rd_d[15:0] = data_q;
         end
         `NVMSDA_OFF_ADDR: begin
            rd_d[23:0] = addr_q;
         end
         default: begin
            rd_d = 32'h00000000;
         end
      endcase
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (xfer && !hwrite) begin
         hrdata <= rd_d;
      end
   end
endmodule

// ### bench/nvmsda_checker.sv
// Concurrent checks on the register block ports.
`timescale 1ns/1ps
module nvmsda_checker (
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [2:0]  hsize,
   input wire        hready,
   input wire [31:0] hwdata,
   input wire [31:0] hrdata,
   input wire        flash_busy,
   input wire        eeprom_busy,
   input wire        rd_valid,
   input wire [1:0]  rd_source,
   input wire [15:0] rd_value,
   input wire        cmd_overlap,
   input wire        eeprom_ready_irq,
   input wire [23:0] target_address,
   input wire [15:0] write_data
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rd_at(a);
      hsel && hready && htrans[1] && !hwrite && haddr == a;
   endsequence
   sequence wr_addr;
      hsel && hready && htrans[1] && hwrite && hsize == 3'h2 && haddr == 32'h00000020;
   endsequence
   // Busy pins pass two sync flops, so four quiet cycles make the bit settled.
   AST_FLASH_BUSY_BIT_RD: assert property (
      $stable(flash_busy) [*4] ##0 rd_at(32'h00000008) |=> hrdata[0] == $past(flash_busy))
      else $error("flash busy bit wrong");
   AST_EEPROM_BUSY_BIT_RD: assert property (
      $stable(eeprom_busy) [*4] ##0 rd_at(32'h00000008) |=> hrdata[1] == $past(eeprom_busy))
      else $error("eeprom busy bit wrong");
   AST_READY_IDLE: assert property (
      !eeprom_busy [*5] ##0 rd_at(32'h00000010) |=> hrdata[0])
      else $error("ready flag not set while idle");
   AST_IRQ_FLAG: assert property (
      eeprom_ready_irq ##0 rd_at(32'h00000010) |=> hrdata[0])
      else $error("irq without ready flag");
   AST_DATA_LOAD: assert property (
      rd_valid && rd_source != 2'h1 |=> write_data == $past(rd_value))
      else $error("data not loaded");
   AST_EE_LOW: assert property (
      rd_valid && rd_source == 2'h1 |=> write_data == {$past(write_data[15:8]), $past(rd_value[7:0])})
      else $error("eeprom read touched high byte");
   AST_ADDR_WR: assert property (
      wr_addr ##1 1'b1 |=> target_address == $past(hwdata[23:0]))
      else $error("address write lost");
   AST_OVERLAP: assert property (
      cmd_overlap ##1 rd_at(32'h00000008) |=> hrdata[6:4] == 3'h3)
      else $error("overlap code missing");
endmodule
bind nvmsda_top nvmsda_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
   .hwdata, .hrdata, .flash_busy, .eeprom_busy, .rd_valid, .rd_source, .rd_value, .cmd_overlap,
   .eeprom_ready_irq, .target_address, .write_data);

// ### bench/nvmsda_mem_model.sv
// Far-side memory model: busy timers for both arrays and a one-cycle read return.
`timescale 1ns/1ps
module nvmsda_mem_model (
   input  wire        hclk,
   input  wire        ee_go,
   input  wire        fl_go,
   input  wire        rd_go,
   input  wire [16:0] rd_req,
   output reg         eeprom_busy,
   output reg         flash_busy,
   output reg         rd_valid,
   output reg  [1:0]  rd_source,
   output reg  [15:0] rd_value
);
   reg [3:0] ee_n = 4'h0;
   reg [3:0] fl_n = 4'h0;
   initial begin
      rd_valid = 1'b0;
      rd_source = 2'h0;
      rd_value = 16'h0000;
   end
   always @(posedge hclk) begin
      ee_n <= ee_go ? 4'hF : ee_n - {3'h0, |ee_n};
      fl_n <= fl_go ? 4'hF : fl_n - {3'h0, |fl_n};
      rd_valid <= rd_go;
      rd_source <= {1'b0, rd_req[16]};
      // An idle read bus shows the inverted last value so stale data never looks fresh.
      rd_value <= rd_go ? rd_req[15:0] : ~rd_value;
   end
   always @* begin
      eeprom_busy = |ee_n;
      flash_busy = |fl_n;
   end
endmodule

// ### bench/tb.sv
// Self-checking bench for the status, data and address register block.
`timescale 1ns/1ps
module tb;
   logic        hclk, hresetn, hwrite, hreadyout, ee_go, fl_go, rd_go, irq;
   logic        flash_busy, eeprom_busy, rd_valid;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0]  htrans, rd_source;
   logic [2:0]  err_p;
   logic [16:0] rd_req;
   logic [15:0] rd_value, write_data;
   logic [23:0] target_address;
   int          mismatches, check_count, cyc;
   localparam logic [95:0] ROWS [4] = '{{32'h00000020, 32'h00ABCDEF, 32'h00ABCDEF},
      {32'h00000018, 32'h0000BEEF, 32'h0000BEEF}, {32'h00000014, 32'h000000FF, 32'h00000000},
      {32'h00000008, 32'h00000070, 32'h00000000}};
   nvmsda_top dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hburst(3'h0),
      .hprot(4'h0), .hmastlock(1'b0), .hready(hreadyout), .hwdata, .hreadyout, .hresp(), .hrdata,
      .flash_busy, .eeprom_busy, .rd_valid, .rd_source, .rd_value, .cmd_unsupported(err_p[0]),
      .cmd_protected(err_p[1]), .cmd_overlap(err_p[2]), .eeprom_ready_irq(irq), .target_address, .write_data);
   nvmsda_mem_model u_mem (.hclk, .ee_go, .fl_go, .rd_go, .rd_req, .eeprom_busy, .flash_busy, .rd_valid,
      .rd_source, .rd_value);
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count = check_count + 1;
      if (s !== e) begin
         mismatches = mismatches + 1;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask
   task give_verdict;
      if (mismatches == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rdv = hrdata;
   endtask
   task rd(input logic [31:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h00000000);
      chk("hrdata", rdv, e);
   endtask
   // Sampled mid-cycle so the edge updates have landed.
   task irq_is(input logic e);
      @(negedge hclk);
      chk("eeprom_ready_irq", {31'h0, irq}, {31'h0, e});
      @(posedge hclk);
   endtask
   task load(input logic [16:0] q);
      rd_req <= q;
      rd_go <= 1'b1;
      @(posedge hclk);
      rd_go <= 1'b0;
      @(posedge hclk);
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches = mismatches + 1;
         give_verdict();
      end
   end
   initial begin
      {hresetn, hwrite, ee_go, fl_go, rd_go, htrans, err_p} = 0;
      {haddr, hwdata, rd_req, mismatches, check_count, cyc} = 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
      rd(32'h00000010, 32'h00000001);
      rd(32'h0000000C, 32'h00000000);
      for (int i = 0; i < 4; i++) begin
         bus(ROWS[i][95:64], 1'b1, ROWS[i][63:32]);
         rd(ROWS[i][95:64], ROWS[i][31:0]);
      end
      chk("target_address", {8'h00, target_address}, 32'h00ABCDEF);
      ee_go <= 1'b1;
      fl_go <= 1'b1;
      @(posedge hclk);
      ee_go <= 1'b0;
      fl_go <= 1'b0;
      repeat (3) @(posedge hclk);
      rd(32'h00000008, 32'h00000003);
      bus(32'h00000010, 1'b1, 32'h00000001);
      rd(32'h00000010, 32'h00000000);
      bus(32'h0000000C, 1'b1, 32'h00000001);
      irq_is(1'b0);
      repeat (14) @(posedge hclk);
      irq_is(1'b1);
      rd(32'h00000010, 32'h00000001);
      bus(32'h0000000C, 1'b1, 32'h00000000);
      irq_is(1'b0);
      // Command changes pass through no-command first, so only the overlap pulse models a collision.
      for (int i = 0; i < 3; i++) begin
         err_p <= 3'h1 << i;
         @(posedge hclk);
         err_p <= 3'h0;
         rd(32'h00000008, (i + 1) << 4);
         bus(32'h00000008, 1'b1, 32'h00000000);
         rd(32'h00000008, 32'h00000000);
      end
      load({1'b0, 16'h1234});
      rd(32'h00000018, 32'h00001234);
      load({1'b1, 16'hAB56});
      rd(32'h00000018, 32'h00001256);
      // A reset in mid-run must return the data and address registers to zero.
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      rd(32'h00000020, 32'h00000000);
      rd(32'h00000018, 32'h00000000);
      give_verdict();
   end
endmodule
